// [sbg_defs.vh]
// Register offsets, field positions, reset values and counts of the baud generator
`ifndef SBG_DEFS_VH
`define SBG_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBG_OFS_DIV_HIGH 5'h00
`define SBG_OFS_DIV_LOW 5'h04
`define SBG_OFS_CONTROL 5'h08
`define SBG_OFS_FLAGS 5'h0c
`define SBG_OFS_STATE 5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBG_HIGH_BREAK_IE 7
`define SBG_HIGH_EDGE_IE 6
`define SBG_HIGH_DIV_MSB 4
`define SBG_CTRL_RX_EN 0
`define SBG_CTRL_TX_EN 1
`define SBG_FLAG_BREAK 0
`define SBG_FLAG_EDGE 1

// ----------------------------------------
// Widths, reset values and the last oversample count
// ----------------------------------------
`define SBG_DIV_WIDTH 13
`define SBG_HIGH_WIDTH 5
`define SBG_DIV_LOW_RESET 8'h01
`define SBG_OVERSAMPLE_LAST 4'hf

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SBG_RESP_OKAY 2'b00
`define SBG_RESP_SLVERR 2'b10

`endif

// [sbg_baud_generator.v]
// Baud rate generator with divisor register pair, enables and interrupt flags
//
// Contract
// RULE_01: One generator per interface times both transmitter and receiver.
// RULE_02: High half buffered; working divisor changes only on low-half write.
// RULE_03: Low half resets nonzero; generator idle until receiver or transmitter enabled.
// RULE_04: Divisor zero stops the generator, no counting.
// RULE_05: Divisor 1 to 8191 gives baud equal to clock over sixteen times divisor.
// RULE_06: Upper five bits in high bits 4:0, lower eight in low bits 7:0.
// RULE_07: High bit 7 lets break-detect flag request an interrupt.
// RULE_08: High bit 6 lets receive-edge flag request an interrupt.
// RULE_09: Full-duplex line with separate receiver and transmitter enables.
// RULE_10: Count clocks modulo divisor for sixteen-times tick; bit clock derived.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sbg_defs.vh"

module sbg_baud_generator (
	input wire sys_clk,
	input wire nrst,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire breakDetectEvent,
	input wire rxEdgeEvent,
	output reg sampleTick,
	output reg bitTick,
	output reg receiverEnable,
	output reg transmitterEnable,
	output reg irq
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg breakDetectIntEnable;
	reg rxEdgeIntEnable;
	reg [4:0] divHighBuf;
	reg [7:0] baudDivisorLow;
	reg [12:0] baudDivisor;
	reg generatorStarted;
	reg breakDetectFlag;
	reg rxEdgeFlag;

	// ----------------------------------------
	// Write channel holding
	// ----------------------------------------
	reg awHeld;
	reg wHeld;
	reg [4:0] wrAddr;
	reg [31:0] wrData;
	reg [3:0] wrStrb;
	wire awTake;
	wire wTake;
	wire doWrite;
	wire wrLane0;
	wire wrHigh;
	wire wrLow;
	wire wrCtrl;
	wire wrFlags;
	wire wrMapped;

	assign awTake = s_axi_awvalid & s_axi_awready;
	assign wTake = s_axi_wvalid & s_axi_wready;
	assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
	assign wrLane0 = wrStrb[0];
	assign wrHigh = doWrite & wrLane0 & ({wrAddr[4:2], 2'b00} == `SBG_OFS_DIV_HIGH);
	assign wrLow = doWrite & wrLane0 & ({wrAddr[4:2], 2'b00} == `SBG_OFS_DIV_LOW);
	assign wrCtrl = doWrite & wrLane0 & ({wrAddr[4:2], 2'b00} == `SBG_OFS_CONTROL);
	assign wrFlags = doWrite & wrLane0 & ({wrAddr[4:2], 2'b00} == `SBG_OFS_FLAGS);
	assign wrMapped = (wrAddr[4:2] <= 3'h4);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= 5'h00;
			wrData <= 32'h00000000;
			wrStrb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SBG_RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld <= 1'b1;
				wrAddr <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (wTake) begin
				wHeld <= 1'b1;
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
			s_axi_awready <= ~awHeld & ~awTake & ~s_axi_bvalid & ~doWrite;
			s_axi_wready <= ~wHeld & ~wTake & ~s_axi_bvalid & ~doWrite;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			breakDetectIntEnable <= 1'b0;
			rxEdgeIntEnable <= 1'b0;
			divHighBuf <= 5'h00;
			baudDivisorLow <= `SBG_DIV_LOW_RESET;
			baudDivisor <= {5'h00, `SBG_DIV_LOW_RESET};
			receiverEnable <= 1'b0;
			transmitterEnable <= 1'b0;
			generatorStarted <= 1'b0;
		end else begin
			if (wrHigh) begin
				breakDetectIntEnable <= wrData[`SBG_HIGH_BREAK_IE]; // [RULE_07]
				rxEdgeIntEnable <= wrData[`SBG_HIGH_EDGE_IE]; // [RULE_08]
				divHighBuf <= wrData[`SBG_HIGH_DIV_MSB:0]; // [RULE_02] [RULE_06]
			end
			if (wrLow) begin
				baudDivisorLow <= wrData[7:0];
				baudDivisor <= {divHighBuf, wrData[7:0]}; // [RULE_02] [RULE_06]
			end
			if (wrCtrl) begin
				receiverEnable <= wrData[`SBG_CTRL_RX_EN]; // [RULE_09]
				transmitterEnable <= wrData[`SBG_CTRL_TX_EN]; // [RULE_09]
				if (wrData[`SBG_CTRL_RX_EN] | wrData[`SBG_CTRL_TX_EN]) begin
					generatorStarted <= 1'b1; // [RULE_03]
				end
			end
		end
	end

	// ----------------------------------------
	// Sticky event flags, set wins over clear
	// ----------------------------------------
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			breakDetectFlag <= 1'b0;
			rxEdgeFlag <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (breakDetectEvent) begin
				breakDetectFlag <= 1'b1;
			end else if (wrFlags & wrData[`SBG_FLAG_BREAK]) begin
				breakDetectFlag <= 1'b0;
			end
			if (rxEdgeEvent) begin
				rxEdgeFlag <= 1'b1;
			end else if (wrFlags & wrData[`SBG_FLAG_EDGE]) begin
				rxEdgeFlag <= 1'b0;
			end
			irq <= (breakDetectFlag & breakDetectIntEnable) | // [RULE_07]
				(rxEdgeFlag & rxEdgeIntEnable); // [RULE_08]
		end
	end

	// ----------------------------------------
	// Modulo divider and oversample counter
	// ----------------------------------------
	reg [12:0] divCount;
	reg [3:0] overCount;
	wire generatorActive;

	assign generatorActive = generatorStarted & (baudDivisor != 13'h0000); // [RULE_03] [RULE_04]

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			divCount <= 13'h0001;
			overCount <= 4'h0;
			sampleTick <= 1'b0;
			bitTick <= 1'b0;
		end else if (!generatorActive || wrLow) begin
			divCount <= 13'h0001; // [RULE_04]
			overCount <= 4'h0;
			sampleTick <= 1'b0;
			bitTick <= 1'b0;
		end else if (divCount >= baudDivisor) begin
			divCount <= 13'h0001; // [RULE_05] [RULE_10]
			sampleTick <= 1'b1; // [RULE_01] [RULE_10]
			overCount <= overCount + 4'h1;
			bitTick <= (overCount == `SBG_OVERSAMPLE_LAST); // [RULE_05] [RULE_10]
		end else begin
			divCount <= divCount + 13'h0001;
			sampleTick <= 1'b0;
			bitTick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	reg [31:0] rdValue;
	reg rdMapped;
	wire arTake;

	assign arTake = s_axi_arvalid & s_axi_arready;

	always @* begin
		rdValue = 32'h00000000;
		rdMapped = 1'b1;
		case (s_axi_araddr[4:2])
			3'h0: begin
				rdValue = {24'h000000, breakDetectIntEnable, rxEdgeIntEnable, 1'b0, divHighBuf};
			end
			3'h1: begin
				rdValue = {24'h000000, baudDivisorLow};
			end
			3'h2: begin
				rdValue = {30'h00000000, transmitterEnable, receiverEnable};
			end
			3'h3: begin
				rdValue = {30'h00000000, rxEdgeFlag, breakDetectFlag};
			end
			3'h4: begin
				rdValue = {18'h00000, overCount, 9'h000, generatorActive};
			end
			default: begin
				rdMapped = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SBG_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~arTake;
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdValue;
				s_axi_rresp <= rdMapped ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// [sbg_line_model.sv]
// Receiver-side event source facing the baud generator
`timescale 1ns/100ps
`default_nettype none
module sbg_line_model (
	input wire logic fireBreak,
	input wire logic fireEdge,
	output logic breakDetectEvent,
	output logic rxEdgeEvent
);
	// One-cycle pulses, launched by the bench on the clock edge
	assign breakDetectEvent = fireBreak;
	assign rxEdgeEvent = fireEdge;
endmodule
`default_nettype wire

// [sbg_checker_properties.sv]
// Checker for the baud generator ports
`timescale 1ns/100ps
`default_nettype none
module sbg_checker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic sampleTick,
	input wire logic bitTick,
	input wire logic receiverEnable,
	input wire logic transmitterEnable,
	input wire logic breakDetectEvent,
	input wire logic rxEdgeEvent,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic seen;
	logic breakDetectOrEdge;
	assign breakDetectOrEdge = breakDetectEvent | rxEdgeEvent;
	// Remembers that an enable has been seen since reset
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			seen <= 1'h0;
		else if (receiverEnable | transmitterEnable)
			seen <= 1'h1;
	end
	a_bit_on_sample: assert property (
		bitTick |-> sampleTick) else $error("bit tick alone");
	a_idle_before_enable: assert property (
		!seen |-> !sampleTick) else $error("early tick");
	a_bit_spacing: assert property (
		bitTick |=> !bitTick [*8] ##1 !bitTick [*7]) else $error("bit tick too soon");
	a_irq_rise_cause: assert property (
		$rose(irq) |-> $past(breakDetectOrEdge, 2) || $past(s_axi_bvalid))
		else $error("irq without cause");
	a_irq_fall_write: assert property (
		$fell(irq) |-> $past(s_axi_bvalid)) else $error("irq fell");
	a_write_refused: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
	a_read_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	a_enable_by_write: assert property (
		$changed(receiverEnable) |-> s_axi_bvalid) else $error("enable moved");
	cover property (bitTick);
	cover property ($rose(irq));
	cover property (s_axi_rvalid);
endmodule
bind sbg_baud_generator sbg_checker sbg_checker_i (.*);
`default_nettype wire

// [sbg_testbench.sv]
// Self-checking bench for the baud generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk = 1'h0, nrst = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic fireBreak = 1'h0, fireEdge = 1'h0;
	logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
	logic [31:0] s_axi_wdata = 32'h0, q;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire sampleTick, bitTick, receiverEnable, transmitterEnable, breakDetectEvent, rxEdgeEvent;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int err_count = 0, checks_done = 0, n;
	logic [4:0] tA [4] = '{5'h00, 5'h04, 5'h08, 5'h14};
	logic [31:0] tD [4] = '{32'hff, 32'h1ab, 32'h2, 32'h5};
	logic [31:0] tE [4] = '{32'hdf, 32'hab, 32'h2, 32'h0};
	sbg_baud_generator sbg_baud_generator_i (.*);
	sbg_line_model sbg_line_model_i (.*);
	always #4 sys_clk = ~sys_clk;
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin
				do @(posedge sys_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'h0;
			end
			begin
				do @(posedge sys_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'h0;
			end
		join
		while (!s_axi_bvalid) @(posedge sys_clk);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask
	task rd(input logic [4:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		q = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	// Cycles between two ticks of one kind
	task gap(input logic b);
		n = 0;
		do @(posedge sys_clk); while ((b ? bitTick : sampleTick) !== 1'h1);
		do begin
			@(posedge sys_clk);
			n++;
		end while ((b ? bitTick : sampleTick) !== 1'h1 && n < 9000);
	endtask
	task cnt(input int c);
		n = 0;
		repeat (c) begin
			@(posedge sys_clk);
			n += sampleTick;
		end
	endtask
	task fire(input logic b);
		@(posedge sys_clk);
		fireBreak <= b;
		fireEdge <= !b;
		@(posedge sys_clk);
		fireBreak <= 1'h0;
		fireEdge <= 1'h0;
		repeat (4) @(posedge sys_clk);
	endtask
	task end_sim;
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			wr(tA[i], tD[i]);
			chk("wresp", rsp, {tA[i] > 5'h10, 1'h0});
			rd(tA[i]);
			chk("rdata", q, tE[i]);
			chk("rresp", rsp, {tA[i] > 5'h10, 1'h0});
		end
		chk("txen", transmitterEnable, 1);
		chk("rxen", receiverEnable, 0);
		nrst <= 1'h0;
		@(posedge sys_clk);
		nrst <= 1'h1;
		rd(5'h04);
		chk("lowrst", q, 32'h1);
		cnt(40);
		chk("idle", n, 0);
		wr(5'h04, 32'h3);
		wr(5'h08, 32'h1);
		gap(0);
		chk("d3", n, 3);
		gap(1);
		chk("bit", n, 48);
		wr(5'h00, 32'h1);
		gap(0);
		chk("buf", n, 3);
		wr(5'h04, 32'h0);
		gap(0);
		chk("d256", n, 256);
		wr(5'h00, 32'h0);
		wr(5'h04, 32'h0);
		cnt(600);
		chk("off", n, 0);
		rd(5'h10);
		chk("state", q, 32'h0);
		fire(1);
		chk("irqoff", irq, 0);
		rd(5'h0c);
		chk("flag", q, 32'h1);
		wr(5'h00, 32'h80);
		repeat (2) @(posedge sys_clk);
		chk("irqb", irq, 1);
		wr(5'h0c, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irqclr", irq, 0);
		wr(5'h00, 32'h40);
		fire(0);
		chk("irqe", irq, 1);
		s_axi_wstrb <= 4'he;
		wr(5'h00, 32'h9f);
		s_axi_wstrb <= 4'hf;
		rd(5'h00);
		chk("strb", q, 32'h40);
		fork
			wr(5'h0c, 32'h2);
			begin
				repeat (2) @(posedge sys_clk);
				fireEdge <= 1'h1;
				@(posedge sys_clk);
				fireEdge <= 1'h0;
			end
		join
		rd(5'h0c);
		chk("setwins", q, 32'h2);
		wr(5'h0c, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk("edgeclr", irq, 0);
		end_sim;
	end
endmodule
`default_nettype wire
